// ==== core/msp_buf2.sv ====
`timescale 1ns/100ps
// two-entry buffer, ready does not depend on out side combinationally
module msp_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    logic [WIDTH-1:0] mem_q [2];
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign push = in_valid_in && (count_q != 2'd2);
    assign pop = out_ready_in && (count_q != 2'd0);
    assign in_ready_out = (count_q != 2'd2);
    assign out_valid_out = (count_q != 2'd0);
    assign out_data_out = mem_q[rd_ptr_q];

    // storage, no reset needed on data
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count_q <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ==== core/msp_pkg.sv ====
package msp_pkg;
    // bit timing
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned NOMINAL_BAUD = 9600;
    localparam int unsigned OVERSAMPLE = 16;
    // rounded to nearest, minus one
    localparam int unsigned RATE_TERMINAL_COUNT =
        (CLK_HZ + (OVERSAMPLE * NOMINAL_BAUD) / 2) / (OVERSAMPLE * NOMINAL_BAUD) - 1;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned TICK_W = 4;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // line ending characters
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_LF = 8'h0a;

    typedef enum logic [1:0] {
        MSP_IDLE = 2'b00,
        MSP_START = 2'b01,
        MSP_DATA = 2'b10,
        MSP_STOP = 2'b11
    } msp_state_t;
endpackage

// ==== core/msp_serial_text_adapter.sv ====
`timescale 1ns/100ps
// Behaviour
// - one transmit and one receive line, both directions at once
// - eight data bits, no parity, one stop bit, no flow control
// - default rate is 9600 baud
// - both directions timed by one sixteen-times-bit-rate enable
// - rate counter counts zero to terminal count, then resets to zero
// - terminal count pulse is the shared time base
// - terminal count is clock over sixteen times baud, rounded, minus one
// - keep rate error within one percent
// - higher standard rates such as 115200 are encouraged
// - transmit byte taken only when write strobe high
// - transmit-full shown whenever no byte can be taken
// - received byte presented, receive-empty while none waits
// - read strobe acknowledges byte, then next byte or empty
module msp_serial_text_adapter #(
    // bit period is sixteen ticks of terminal count plus one clocks
    parameter int unsigned RATE_TERMINAL_COUNT =
        msp_pkg::RATE_TERMINAL_COUNT
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_write_in,
    output logic tx_full_out,
    output logic [7:0] rx_byte_out,
    input wire logic rx_read_in,
    output logic rx_empty_out,
    output logic serial_tx_out,
    input wire logic serial_rx_in
);
    localparam int unsigned CNT_W = $clog2(RATE_TERMINAL_COUNT + 1) + 1;
    localparam logic [CNT_W-1:0] TC = CNT_W'(RATE_TERMINAL_COUNT);

    logic [CNT_W-1:0] rate_cnt_q;
    logic tick_q;

    // rate counter; period is terminal count plus one clocks
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rate_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (rate_cnt_q == TC) begin
            rate_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            rate_cnt_q <= rate_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ---- transmit side ----
    logic txb_ready;
    logic txb_valid;
    logic [7:0] txb_data;
    logic tx_take;
    msp_pkg::msp_state_t tx_state_q;
    logic [3:0] tx_tick_q;
    logic [3:0] tx_bit_q;
    logic [7:0] tx_shift_q;

    // take only on a tick, else the start bit is cut short by part of a tick
    assign tx_take = (tx_state_q == msp_pkg::MSP_IDLE) && txb_valid && tick_q;

    // buffer decouples controller writes from the slow shifter
    msp_buf2 #(.WIDTH(8)) u_tx_buf (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(tx_write_in),
        .in_data_in(tx_byte_in),
        .in_ready_out(txb_ready),
        .out_valid_out(txb_valid),
        .out_data_out(txb_data),
        .out_ready_in(tx_take)
    );

    // full flag registered; a write in a cycle where full was just raised is
    // still absorbed if the buffer has room, because ready is read directly by the buffer
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tx_full_out <= 1'b1;
        end else begin
            tx_full_out <= !txb_ready || (tx_write_in && !tx_take);
        end
    end

    // transmit frame sequencer, advances only on the shared tick
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tx_state_q <= msp_pkg::MSP_IDLE;
            tx_tick_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_shift_q <= msp_pkg::DATA_RESET;
            serial_tx_out <= 1'b1;
        end else begin
            case (tx_state_q)
                msp_pkg::MSP_IDLE: begin
                    serial_tx_out <= 1'b1;
                    if (tx_take) begin
                        tx_shift_q <= txb_data;
                        tx_state_q <= msp_pkg::MSP_START;
                        tx_tick_q <= 4'h0;
                    end
                end
                msp_pkg::MSP_START: begin
                    serial_tx_out <= 1'b0;
                    if (tick_q) begin
                        tx_tick_q <= tx_tick_q + 4'h1;
                        if (tx_tick_q == msp_pkg::TICK_LAST) begin
                            tx_state_q <= msp_pkg::MSP_DATA;
                            tx_bit_q <= 4'h0;
                        end
                    end
                end
                msp_pkg::MSP_DATA: begin
                    serial_tx_out <= tx_shift_q[0];
                    if (tick_q) begin
                        tx_tick_q <= tx_tick_q + 4'h1;
                        if (tx_tick_q == msp_pkg::TICK_LAST) begin
                            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                            tx_bit_q <= tx_bit_q + 4'h1;
                            if (tx_bit_q == msp_pkg::BIT_LAST) begin
                                tx_state_q <= msp_pkg::MSP_STOP;
                            end
                        end
                    end
                end
                msp_pkg::MSP_STOP: begin
                    serial_tx_out <= 1'b1;
                    if (tick_q) begin
                        tx_tick_q <= tx_tick_q + 4'h1;
                        if (tx_tick_q == msp_pkg::TICK_LAST) begin
                            tx_state_q <= msp_pkg::MSP_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_q <= msp_pkg::MSP_IDLE;
                end
            endcase
        end
    end

    // ---- receive side ----
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_armed_q;
    msp_pkg::msp_state_t rx_state_q;
    logic [3:0] rx_tick_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_shift_q;
    logic rx_done_q;
    logic rxb_ready;
    logic rxb_valid;
    logic [7:0] rxb_data;
    logic rx_pop;

    // two-flop synchroniser; reset high so no false start
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= serial_rx_in;
            rx_sync_q <= rx_meta_q;
        end
    end

    // receive sequencer; start checked at mid-bit to reject glitches
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rx_state_q <= msp_pkg::MSP_IDLE;
            rx_tick_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_shift_q <= msp_pkg::DATA_RESET;
            rx_armed_q <= 1'b0;
            rx_done_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            case (rx_state_q)
                msp_pkg::MSP_IDLE: begin
                    // a start needs the line high first, so a low stop cannot restart
                    if (rx_sync_q) begin
                        rx_armed_q <= 1'b1;
                    end
                    if (tick_q && !rx_sync_q && rx_armed_q) begin
                        rx_state_q <= msp_pkg::MSP_START;
                        rx_tick_q <= 4'h1;
                        rx_armed_q <= 1'b0;
                    end
                end
                msp_pkg::MSP_START: begin
                    if (tick_q) begin
                        rx_tick_q <= rx_tick_q + 4'h1;
                        if (rx_tick_q == msp_pkg::TICK_MID) begin
                            if (rx_sync_q) begin
                                rx_state_q <= msp_pkg::MSP_IDLE;
                            end else begin
                                rx_state_q <= msp_pkg::MSP_DATA;
                                rx_tick_q <= 4'h0;
                                rx_bit_q <= 4'h0;
                            end
                        end
                    end
                end
                msp_pkg::MSP_DATA: begin
                    if (tick_q) begin
                        rx_tick_q <= rx_tick_q + 4'h1;
                        if (rx_tick_q == msp_pkg::TICK_LAST) begin
                            rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == msp_pkg::BIT_LAST) begin
                                rx_state_q <= msp_pkg::MSP_STOP;
                            end
                        end
                    end
                end
                msp_pkg::MSP_STOP: begin
                    if (tick_q) begin
                        rx_tick_q <= rx_tick_q + 4'h1;
                        if (rx_tick_q == msp_pkg::TICK_LAST) begin
                            rx_state_q <= msp_pkg::MSP_IDLE;
                            // framing error drops the byte silently
                            rx_done_q <= rx_sync_q;
                        end
                    end
                end
                default: begin
                    rx_state_q <= msp_pkg::MSP_IDLE;
                end
            endcase
        end
    end

    // line has no flow control: a byte arriving on a full buffer is lost
    msp_buf2 #(.WIDTH(8)) u_rx_buf (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(rx_done_q),
        .in_data_in(rx_shift_q),
        .in_ready_out(rxb_ready),
        .out_valid_out(rxb_valid),
        .out_data_out(rxb_data),
        .out_ready_in(rx_pop)
    );

    // output stage holds the presented byte; refilled from the buffer
    assign rx_pop = rxb_valid && (rx_empty_out || rx_read_in);

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rx_empty_out <= 1'b1;
            rx_byte_out <= msp_pkg::DATA_RESET;
        end else if (rx_pop) begin
            rx_byte_out <= rxb_data;
            rx_empty_out <= 1'b0;
        end else if (rx_read_in) begin
            rx_empty_out <= 1'b1;
        end
    end
endmodule

// ==== dv/msp_mon_monitor.sv ====
`timescale 1ns/100ps
// pin watcher; the bit length follows the rate parameter handed on by the bind
module msp_pin_check #(
    parameter int unsigned RATE_TERMINAL_COUNT = msp_pkg::RATE_TERMINAL_COUNT
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_write_in,
    input wire logic tx_full_out,
    input wire logic [7:0] rx_byte_out,
    input wire logic rx_read_in,
    input wire logic rx_empty_out,
    input wire logic serial_tx_out,
    input wire logic serial_rx_in
);
    localparam int unsigned BIT_CLKS = 16 * (RATE_TERMINAL_COUNT + 1);
    logic last_q;
    logic [31:0] run_q;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // run length of the present line level; reset parks it at idle high
    always_ff @(posedge clk_sys_in) begin
        last_q <= serial_tx_out | ~rst_n_in;
        run_q <= (!rst_n_in || serial_tx_out != last_q) ? 32'h00000001 : run_q + 32'h00000001;
    end
    reset_idle_a: assert property (disable iff (1'b0)
        !rst_n_in |=> serial_tx_out && tx_full_out && rx_empty_out
        && rx_byte_out == msp_pkg::DATA_RESET) else $error("reset levels wrong");
    full_release_a: assert property ($rose(rst_n_in) |=> !tx_full_out)
        else $error("tx full stuck after reset");
    low_run_a: assert property (serial_tx_out && !last_q |-> run_q % BIT_CLKS == 0)
        else $error("low run is not whole bits");
    low_max_a: assert property (!serial_tx_out && !last_q |->
        run_q < 9 * BIT_CLKS) else $error("line low too long");
    full_cause_a: assert property ($rose(tx_full_out) |->
        $past(tx_write_in) || $past(tx_write_in, 2)) else $error("full without write");
    rx_hold_a: assert property (!rx_empty_out && !rx_read_in |=>
        !rx_empty_out && $stable(rx_byte_out)) else $error("rx byte moved");
    empty_cause_a: assert property ($rose(rx_empty_out) |-> $past(rx_read_in))
        else $error("empty without read");
    rx_stop_a: assert property ($fell(rx_empty_out) |-> serial_rx_in)
        else $error("byte out before stop");
endmodule

bind msp_serial_text_adapter msp_pin_check #(.RATE_TERMINAL_COUNT(RATE_TERMINAL_COUNT))
    i_msp_pin_check (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .tx_byte_in(tx_byte_in),
    .tx_write_in(tx_write_in), .tx_full_out(tx_full_out), .rx_byte_out(rx_byte_out),
    .rx_read_in(rx_read_in), .rx_empty_out(rx_empty_out), .serial_tx_out(serial_tx_out),
    .serial_rx_in(serial_rx_in));

// ==== dv/msp_serial_text_adapter_tb.sv ====
`timescale 1ns/100ps
// controller side driven here, serial side worked through the terminal model
module msp_serial_text_adapter_tb;
    localparam int unsigned TC = 3; // shortened rate keeps frames at 640 clocks
    localparam int unsigned BIT_CLKS = 16 * (TC + 1);
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] tx_byte_in = 8'h00;
    logic tx_write_in = 1'b0;
    logic rx_read_in = 1'b0;
    logic tx_full_out, rx_empty_out, serial_tx_out, serial_rx_in;
    logic [7:0] rx_byte_out;
    int n_fail = 0;
    int total_checks = 0;
    logic [7:0] tx_tbl [4] = '{8'h41, 8'h00, 8'hff, 8'h0d};
    logic [7:0] rx_tbl [4] = '{8'h31, 8'ha5, 8'h0d, 8'h7e};
    msp_serial_text_adapter #(.RATE_TERMINAL_COUNT(TC)) i_msp_serial_text_adapter (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .tx_byte_in(tx_byte_in),
        .tx_write_in(tx_write_in), .tx_full_out(tx_full_out), .rx_byte_out(rx_byte_out),
        .rx_read_in(rx_read_in), .rx_empty_out(rx_empty_out),
        .serial_tx_out(serial_tx_out), .serial_rx_in(serial_rx_in));
    msp_term #(.BIT_CLKS(BIT_CLKS)) i_msp_term (
        .clk_sys_in(clk_sys_in), .line_in(serial_tx_out), .line_out(serial_rx_in));
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bounded wait: 0 for room to write, 1 for n characters at the terminal
    task automatic wait_cond(input int which, input int n);
        int k;
        for (k = 0; k < 5000; k++) begin
            @(negedge clk_sys_in);
            if (which == 0 && tx_full_out === 1'b0) break;
            if (which == 1 && i_msp_term.got_q.size() >= n) break;
        end
        if (k == 5000) begin
            check(1'b0, "wait ran out");
            close_out();
        end
    endtask
    task automatic reset_and_check(input int n);
        rst_n_in = 1'b0;
        repeat (n) @(negedge clk_sys_in);
        check(serial_tx_out === 1'b1 && tx_full_out === 1'b1, "reset tx");
        check(rx_empty_out === 1'b1 && rx_byte_out === 8'h00, "reset rx");
        rst_n_in = 1'b1;
        wait_cond(0, 0);
        $display("test reset done");
    endtask
    // both directions at once; writes stall on full, reads held off until the end
    task automatic t_duplex();
        int i;
        logic saw_full;
        i = 0;
        saw_full = 1'b0;
        fork
            begin
                for (int k = 0; k < 3000 && i < 4; k++) begin
                    @(negedge clk_sys_in);
                    saw_full |= tx_full_out;
                    tx_write_in = !tx_full_out;
                    tx_byte_in = tx_tbl[i];
                    if (!tx_full_out) i++;
                end
                @(negedge clk_sys_in);
                tx_write_in = 1'b0;
            end
            begin
                i_msp_term.send_char(8'h55, 1'b0);
                repeat (2 * BIT_CLKS) @(negedge clk_sys_in);
                foreach (rx_tbl[j]) i_msp_term.send_char(rx_tbl[j], 1'b1);
            end
        join
        wait_cond(1, 4);
        check(i === 4 && saw_full === 1'b1, "tx full never seen");
        foreach (tx_tbl[j]) check(i_msp_term.got_q[j] === tx_tbl[j], "tx char");
        check(i_msp_term.lf_seen == 1, "cr expansion");
        for (int j = 0; j < 3; j++) begin
            @(negedge clk_sys_in);
            check(!rx_empty_out && rx_byte_out === rx_tbl[j], "rx char");
            rx_read_in = 1'b1;
        end
        @(negedge clk_sys_in);
        rx_read_in = 1'b0;
        check(rx_empty_out === 1'b1, "rx not drained");
        rx_read_in = 1'b1;
        @(negedge clk_sys_in);
        rx_read_in = 1'b0;
        @(negedge clk_sys_in);
        check(rx_empty_out === 1'b1 && serial_tx_out === 1'b1, "idle after read");
        $display("test duplex done");
    endtask
    initial begin
        reset_and_check(5);
        t_duplex();
        repeat (100) @(negedge clk_sys_in);
        reset_and_check(2);
        close_out();
    end
endmodule

// ==== dv/msp_term.sv ====
`timescale 1ns/100ps
// terminal on the serial pair: 8-N-1, no flow control, CR shown as CR LF
module msp_term #(
    parameter int unsigned BIT_CLKS = 64
) (
    input wire logic clk_sys_in,
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got_q[$];
    int lf_seen = 0;
    initial line_out = 1'b1;
    // one character; the caller picks the stop level to make a bad frame
    task automatic send_char(input logic [7:0] ch, input logic stop);
        @(negedge clk_sys_in);
        line_out = 1'b0;
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CLKS) @(negedge clk_sys_in);
            line_out = (i < 8) ? ch[i] : ((i == 8) ? stop : 1'b1);
        end
    endtask
    // mid-bit sampling; a low stop bit throws the frame away
    initial begin
        logic [7:0] sh;
        forever begin
            @(negedge line_in);
            repeat (BIT_CLKS / 2) @(posedge clk_sys_in);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_CLKS) @(posedge clk_sys_in);
                if (i < 8) sh[i] = line_in;
            end
            if (line_in === 1'b1) begin
                got_q.push_back(sh);
                if (sh === msp_pkg::CHAR_CR) lf_seen++;
            end
        end
    end
endmodule
